// [sssp_consts.vh]
// Constants for the serial port status, prescale and interrupt id registers.
// Assumes a 32-bit register port with byte offsets.
`ifndef SSSP_CONSTS_VH
`define SSSP_CONSTS_VH

// Register byte offsets
`define SSSP_ADDR_W 8
`define SSSP_OFS_STATUS 8'h0C
`define SSSP_OFS_PRESCALE 8'h10
`define SSSP_OFS_IRQ_ID 8'h14

// Status register fields
`define SSSP_ST_TX_EMPTY 0
`define SSSP_ST_TX_NOT_FULL 1
`define SSSP_ST_RX_NOT_EMPTY 2
`define SSSP_ST_RX_FULL 3
`define SSSP_ST_BUSY 4
`define SSSP_ST_RESET 32'h00000003

// Interrupt identification fields
`define SSSP_ID_RX_SERVICE 0
`define SSSP_ID_TX_SERVICE 1
`define SSSP_ID_OVERRUN 2

// Prescale divisor field
`define SSSP_DIV_W 8
`define SSSP_DIV_MSB 7
`define SSSP_DIV_RESET 8'h00

// FIFO geometry
`define SSSP_LVL_W 4
`define SSSP_FIFO_DEPTH 4'h8
`define SSSP_FIFO_HALF 4'h4
`define SSSP_LVL_ZERO 4'h0

// Common values
`define SSSP_WORD_ZERO 32'h00000000
`define SSSP_CNT_ONE 8'h01

`endif

// [sssp_regs.v]
// Status, clock prescale and interrupt identification registers of the
// synchronous serial port, with the prescale divider and interrupt lines.
// Assumes FIFO levels, frame activity, overrun events and interrupt enables
// arrive from logic on clk_i; the register port never stalls.
//
// What this block does
// (R01) Status register is read-only and resets to 0x0003.
// (R02) Bit 4 busy while a frame moves or transmit FIFO holds data.
// (R03) Bit 3 set when the receive FIFO has no free entry.
// (R04) Bit 2 set when the receive FIFO holds at least one entry.
// (R05) Bit 1 clear only when the transmit FIFO is full.
// (R06) Bit 0 set when the transmit FIFO is empty.
// (R07) Status bits 31:5 reserved; software ignores them, here they read zero.
// (R08) Prescale bits 7:0 hold the divisor, reset zero, dividing the clock.
// (R09) Divisor bit 0 is fixed at zero on write and read.
// (R10) Software programs an even divisor from 2 to 254.
// (R11) Software writes zero into prescale bits 31:8.
// (R12) Reads at 0x14 return interrupt status; writes there are overrun clear.
// (R13) Id bit 2 follows the receive overrun interrupt line.
// (R14) Id bit 1 follows the transmit service interrupt line.
// (R15) Id bit 0 follows the receive service interrupt line.
// (R16) Id bits 31:3 always read zero.
// (R17) Enabled transmit service interrupt asserts at half-full or less.
// (R18) Enabled receive service interrupt asserts at half-full or more.
// (R19) Any write to 0x14 clears only the overrun interrupt.
// (R20) Reads show current state and have no side effects.
//
// Notes for integrators
// - Status and id reads show the state seen at the read edge.
// - Overrun: an event in the same cycle as a clear write wins;
//   enable low clears the interrupt over any event.
// - The divider runs from clk_i; a zero divisor stops the tick
//   and any divisor write restarts the count.
// - FIFO depth is eight entries; the half-full mark is four.
// - Reserved status bits read zero; software must not rely on it.
// - Read data stands for one cycle, then falls back to zero.
`include "sssp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module sssp_regs
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,

    // Register port
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,

    // Port state from the FIFOs and shifters
    input wire [3:0] tx_level_i,
    input wire [3:0] rx_level_i,
    input wire frame_active_i,
    input wire overrun_event_i,

    // Interrupt enables from the control register
    input wire overrun_en_i,
    input wire tx_irq_en_i,
    input wire rx_irq_en_i,

    // Interrupt lines
    output reg rx_overrun_irq_o,
    output reg tx_service_irq_o,
    output reg rx_service_irq_o,

    // Prescaled clock
    output reg [7:0] prescale_divisor_o,
    output reg prescale_tick_o
);

    // Register state
    reg [7:0] div_ff;
    reg [7:0] nxt_div;
    reg [7:0] cnt_ff;
    reg [7:0] nxt_cnt;
    reg tick_ff;
    reg nxt_tick;
    reg ovr_ff;
    reg nxt_ovr;
    reg txs_ff;
    reg nxt_txs;
    reg rxs_ff;
    reg nxt_rxs;
    reg [31:0] rdata_ff;
    reg [31:0] nxt_rdata;

    // Decoded accesses
    wire wr_prescale;
    wire wr_clear;
    wire [31:0] status_word;
    wire [31:0] id_word;
    wire [31:0] prescale_word;

    // Address decode for the writable locations
    assign wr_prescale = wr_i && (addr_i == `SSSP_OFS_PRESCALE);
    assign wr_clear = wr_i && (addr_i == `SSSP_OFS_IRQ_ID); // see (R19)

    // Status word built from live FIFO state, reserved bits zero
    assign status_word[`SSSP_ST_TX_EMPTY] =
        (tx_level_i == `SSSP_LVL_ZERO); // see (R06)
    assign status_word[`SSSP_ST_TX_NOT_FULL] =
        (tx_level_i != `SSSP_FIFO_DEPTH); // see (R05)
    assign status_word[`SSSP_ST_RX_NOT_EMPTY] =
        (rx_level_i != `SSSP_LVL_ZERO); // see (R04)
    assign status_word[`SSSP_ST_RX_FULL] =
        (rx_level_i == `SSSP_FIFO_DEPTH); // see (R03)
    assign status_word[`SSSP_ST_BUSY] =
        frame_active_i || (tx_level_i != `SSSP_LVL_ZERO); // see (R02)
    assign status_word[31:5] = 27'h0000000; // see (R07)

    // Interrupt id word from the interrupt line flops
    assign id_word[`SSSP_ID_RX_SERVICE] = rxs_ff; // see (R15)
    assign id_word[`SSSP_ID_TX_SERVICE] = txs_ff; // see (R14)
    assign id_word[`SSSP_ID_OVERRUN] = ovr_ff; // see (R13)
    assign id_word[31:3] = 29'h00000000; // see (R16)

    // Prescale word, upper reserved bits zero
    assign prescale_word = {24'h000000, div_ff};

    // Divisor register: even values only
    always @*
    begin
        nxt_div = div_ff;
        if (wr_prescale)
        begin
            nxt_div = {wdata_i[`SSSP_DIV_MSB:1], 1'b0}; // see (R09)
        end
    end

    // Prescale counter; a zero divisor stops the tick
    always @*
    begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        if (wr_prescale || (div_ff == `SSSP_DIV_RESET))
        begin
            nxt_cnt = `SSSP_DIV_RESET;
        end
        else if (cnt_ff >= (div_ff - `SSSP_CNT_ONE))
        begin
            nxt_cnt = `SSSP_DIV_RESET;
            nxt_tick = 1'b1; // see (R08)
        end
        else
        begin
            nxt_cnt = cnt_ff + `SSSP_CNT_ONE;
        end
    end

    // Overrun interrupt: sticky, a new event wins over the clear
    always @*
    begin
        nxt_ovr = ovr_ff;
        if (!overrun_en_i)
        begin
            nxt_ovr = 1'b0;
        end
        else if (overrun_event_i)
        begin
            nxt_ovr = 1'b1;
        end
        else if (wr_clear)
        begin
            nxt_ovr = 1'b0; // see (R19)
        end
    end

    // Service interrupts follow FIFO thresholds
    always @*
    begin
        nxt_txs = tx_irq_en_i && (tx_level_i <= `SSSP_FIFO_HALF); // see (R17)
        nxt_rxs = rx_irq_en_i && (rx_level_i >= `SSSP_FIFO_HALF); // see (R18)
    end

    // Read mux; reads change no state
    always @*
    begin
        nxt_rdata = `SSSP_WORD_ZERO;
        if (rd_i)
        begin
            case (addr_i)
                `SSSP_OFS_STATUS:
                begin
                    nxt_rdata = status_word; // see (R20)
                end
                `SSSP_OFS_PRESCALE:
                begin
                    nxt_rdata = prescale_word; // see (R09)
                end
                `SSSP_OFS_IRQ_ID:
                begin
                    nxt_rdata = id_word; // see (R12)
                end
                default:
                begin
                    nxt_rdata = `SSSP_WORD_ZERO;
                end
            endcase
        end
    end

    // Divisor and prescale counter registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            div_ff <= `SSSP_DIV_RESET; // see (R08)
            cnt_ff <= `SSSP_DIV_RESET;
            tick_ff <= 1'b0;
        end
        else
        begin
            div_ff <= nxt_div;
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // Interrupt line registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ovr_ff <= 1'b0;
            txs_ff <= 1'b0;
            rxs_ff <= 1'b0;
        end
        else
        begin
            ovr_ff <= nxt_ovr;
            txs_ff <= nxt_txs;
            rxs_ff <= nxt_rxs;
        end
    end

    // Read data register
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_ff <= `SSSP_WORD_ZERO;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Read data output flop, zero outside the answer cycle
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rdata_o <= `SSSP_WORD_ZERO;
        end
        else
        begin
            rdata_o <= nxt_rdata; // see (R01)
        end
    end

    // Interrupt output flops mirror the line registers
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rx_overrun_irq_o <= 1'b0;
            tx_service_irq_o <= 1'b0;
            rx_service_irq_o <= 1'b0;
        end
        else
        begin
            rx_overrun_irq_o <= nxt_ovr;
            tx_service_irq_o <= nxt_txs;
            rx_service_irq_o <= nxt_rxs;
        end
    end

    // Divisor and tick output flops
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            prescale_divisor_o <= `SSSP_DIV_RESET;
            prescale_tick_o <= 1'b0;
        end
        else
        begin
            prescale_divisor_o <= nxt_div;
            prescale_tick_o <= nxt_tick;
        end
    end

endmodule // sssp_regs

`default_nettype wire

// [sssp_regs_asserts.sv]
// Checker for the serial port status, prescale and interrupt id registers.
// Assumes it is bound to sssp_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sssp_regs_asserts
(
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Register port
    input wire [7:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    // Port state and enables
    input wire [3:0] tx_level_i,
    input wire [3:0] rx_level_i,
    input wire frame_active_i,
    input wire overrun_event_i,
    input wire overrun_en_i,
    input wire tx_irq_en_i,
    input wire rx_irq_en_i,
    // Interrupt lines and divisor
    input wire rx_overrun_irq_o,
    input wire tx_service_irq_o,
    input wire rx_service_irq_o,
    input wire [7:0] prescale_divisor_o
);
    // Expected status bits and service conditions from the inputs
    wire [4:0] st = {frame_active_i | (tx_level_i != 4'h0), rx_level_i == 4'h8,
        rx_level_i != 4'h0, tx_level_i != 4'h8, tx_level_i == 4'h0};
    wire txq = tx_irq_en_i && tx_level_i <= 4'h4;
    wire rxq = rx_irq_en_i && rx_level_i >= 4'h4;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ST: assert property (rd_i && addr_i == 8'h0C |=> rdata_o == {27'h0, $past(st)})
        else $error("status read wrong");
    AST_PRE_WR: assert property (wr_i && addr_i == 8'h10 |=> prescale_divisor_o == {$past(wdata_i[7:1]), 1'h0})
        else $error("divisor write wrong");
    AST_PRE_RD: assert property (rd_i && addr_i == 8'h10 |=> rdata_o == {24'h0, $past(prescale_divisor_o)})
        else $error("divisor read wrong");
    AST_ID: assert property (rd_i && addr_i == 8'h14 |=> rdata_o == {29'h0, $past(rx_overrun_irq_o),
        $past(tx_service_irq_o), $past(rx_service_irq_o)})
        else $error("irq id read wrong");
    AST_TXI: assert property (1'h1 |=> tx_service_irq_o == $past(txq))
        else $error("tx service irq wrong");
    AST_RXI: assert property (1'h1 |=> rx_service_irq_o == $past(rxq))
        else $error("rx service irq wrong");
    AST_OVR_SET: assert property (overrun_event_i && overrun_en_i |=> rx_overrun_irq_o)
        else $error("overrun not set");
    AST_OVR_CLR: assert property (wr_i && addr_i == 8'h14 && !overrun_event_i |=> !rx_overrun_irq_o)
        else $error("overrun not cleared");
endmodule // sssp_regs_asserts
`default_nettype wire

// [sssp_regs_tb.sv]
// Self-checking bench for the serial port register block.
// Assumes sssp_regs and its checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module sssp_regs_tb;
    logic clk_i = 1'h0, rst_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, frame_active_i = 1'h0;
    logic overrun_event_i = 1'h0, overrun_en_i = 1'h0, tx_irq_en_i = 1'h0, rx_irq_en_i = 1'h0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, d, w;
    logic [3:0] tx_level_i = 4'h0, rx_level_i = 4'h0;
    logic ovr = 1'h0;
    wire [31:0] rdata_o;
    wire [7:0] prescale_divisor_o;
    wire rx_overrun_irq_o, tx_service_irq_o, rx_service_irq_o, prescale_tick_o;
    integer seed = 32'hD263F4F2, n_mismatch = 0, tests_run = 0, i, k;
    sssp_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tx_level_i(tx_level_i),
        .rx_level_i(rx_level_i), .frame_active_i(frame_active_i),
        .overrun_event_i(overrun_event_i), .overrun_en_i(overrun_en_i),
        .tx_irq_en_i(tx_irq_en_i), .rx_irq_en_i(rx_irq_en_i),
        .rx_overrun_irq_o(rx_overrun_irq_o), .tx_service_irq_o(tx_service_irq_o),
        .rx_service_irq_o(rx_service_irq_o), .prescale_divisor_o(prescale_divisor_o),
        .prescale_tick_o(prescale_tick_o));
    // 40 MHz clock
    initial forever #12.5 clk_i = ~clk_i;
    // Expected status word and interrupt id word
    function automatic logic [31:0] f_st();
        return {27'h0, frame_active_i | (tx_level_i != 4'h0), rx_level_i == 4'h8,
            rx_level_i != 4'h0, tx_level_i != 4'h8, tx_level_i == 4'h0};
    endfunction
    function automatic logic [31:0] f_id();
        return {29'h0, ovr, tx_irq_en_i && tx_level_i <= 4'h4, rx_irq_en_i && rx_level_i >= 4'h4};
    endfunction
    // Compare one word and count it
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    // One write cycle, then let its updates land
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'h1;
        @(posedge clk_i);
        wr_i <= 1'h0;
        #1;
    endtask
    // One read cycle; data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'h1;
        @(posedge clk_i);
        rd_i <= 1'h0;
        #1 d = rdata_o;
    endtask
    // Verdict and end of run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        rd(8'h0C);
        chk("status", 32'h3, d);
        rd(8'h10);
        chk("prescale", 32'h0, d);
        rd(8'h14);
        chk("irq id", 32'h0, d);
        rd(8'h20);
        chk("unmapped", 32'h0, d);
        @(posedge clk_i);
        #1 chk("rdata idle", 32'h0, rdata_o);
        $display("reset test done");
        wr(8'h10, 32'h5);
        chk("divisor", 32'h4, {24'h0, prescale_divisor_o});
        k = 0;
        repeat (40)
        begin
            @(posedge clk_i);
            #1 k += prescale_tick_o;
        end
        chk("ticks", 32'hA, k);
        $display("prescale test done");
        overrun_en_i <= 1'h1;
        overrun_event_i <= 1'h1;
        @(posedge clk_i);
        overrun_event_i <= 1'h0;
        ovr = 1'h1;
        rd(8'h14);
        chk("overrun set", f_id(), d);
        rd(8'h14);
        chk("read keeps", f_id(), d);
        wr(8'h14, $random(seed));
        ovr = 1'h0;
        rd(8'h14);
        chk("overrun clear", f_id(), d);
        overrun_event_i <= 1'h1;
        wr(8'h14, 32'h0);
        overrun_event_i <= 1'h0;
        ovr = 1'h1;
        rd(8'h14);
        chk("set wins", f_id(), d);
        overrun_en_i <= 1'h0;
        @(posedge clk_i);
        ovr = 1'h0;
        rd(8'h14);
        chk("enable clear", f_id(), d);
        $display("overrun test done");
        // Level sweep then random levels, enables and divisors
        for (i = 0; i < 40; i++)
        begin
            w = $random(seed);
            tx_level_i <= (i < 9) ? i[3:0] : w[3:0] % 4'h9;
            rx_level_i <= (i < 9) ? 4'h8 - i[3:0] : w[7:4] % 4'h9;
            frame_active_i <= w[8];
            tx_irq_en_i <= w[9];
            rx_irq_en_i <= w[10];
            wr(8'h0C, w);
            wr(8'h10, {24'h0, w[7:1] | 7'h01, 1'h0});
            rd(8'h0C);
            chk("status", f_st(), d);
            rd(8'h14);
            chk("irq id", f_id(), d);
            rd(8'h10);
            chk("prescale", {24'h0, w[7:1] | 7'h01, 1'h0}, d);
        end
        $display("random test done");
        tally_and_finish();
    end
endmodule // sssp_regs_tb
bind sssp_regs sssp_regs_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .tx_level_i(tx_level_i), .rx_level_i(rx_level_i), .frame_active_i(frame_active_i),
    .overrun_event_i(overrun_event_i), .overrun_en_i(overrun_en_i),
    .tx_irq_en_i(tx_irq_en_i), .rx_irq_en_i(rx_irq_en_i),
    .rx_overrun_irq_o(rx_overrun_irq_o), .tx_service_irq_o(tx_service_irq_o),
    .rx_service_irq_o(rx_service_irq_o), .prescale_divisor_o(prescale_divisor_o));
`default_nettype wire
